// >>> src/asr_pkg.sv
// shared constants and types for the serial result readout block
package asr_pkg;
	localparam int unsigned CODE_W = 12;
	localparam int unsigned RES_12 = 12;
	localparam int unsigned RES_10 = 10;
	localparam int unsigned RES_8 = 8;
	localparam int unsigned FRAME_LEN = 16;
	localparam int unsigned LEAD_ZEROS = 4;
	localparam int unsigned CNT_W = 5;
	localparam int unsigned BUF_DEPTH = 2;
	localparam int unsigned CORE_PERIOD_NS = 20;
	localparam int unsigned T_QUIET_NS = 50;
	localparam int unsigned QUIET_CYCLES = (T_QUIET_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam logic [CNT_W-1:0] CNT_LEAD = 5'h04;
	localparam logic [CNT_W-1:0] CNT_END = 5'h10;
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
	localparam logic [CODE_W-1:0] CODE_ONE = 12'h001;

	typedef enum logic [1:0] {
		ST_TRACK = 2'b00,
		ST_HOLD = 2'b01,
		ST_DONE = 2'b10
	} asr_th_e;

	typedef struct packed {
		logic data;
		logic oe;
	} asr_pin_s;

	// weight of the bit under trial, counted from the frame position
	function automatic logic [CODE_W-1:0] trial_mask(input logic [CNT_W-1:0] pos,
			input int unsigned res);
		logic [CNT_W-1:0] b;
		b = CNT_W'(res - 1) - (pos - CNT_LEAD);
		return CODE_ONE << b;
	endfunction
endpackage

// >>> src/asr_buf2.sv
// two-entry valid/ready buffer with registered flags
`timescale 1ns/10ps
`default_nettype none
module asr_buf2 #(
	parameter int unsigned W = 12,
	parameter int unsigned DEPTH = 2
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [W-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic full_r, full_nxt, push, pop;

	assign push = i_valid & ~full_r;
	assign pop = i_ready & (cnt_r != '0);
	assign o_valid = (cnt_r != '0);
	assign o_data = mem_r[rp_r];

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push) begin
			mem_nxt[wp_r] = i_data;
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		end
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		full_nxt = (cnt_nxt == (PW+1)'(DEPTH));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			full_r <= 1'b0;
			o_ready <= 1'b1;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			full_r <= full_nxt;
			o_ready <= ~full_nxt;
		end
	end
endmodule // asr_buf2
`default_nettype wire

// >>> src/asr_readout.sv
// converter control and serial result readout, device side
// Summary of operation
// - serial clock times both shifting and each successive-approximation step
// - result output changes on every falling serial clock edge
// - 12-bit: four zeros then twelve result bits, msb first
// - 10-bit: four zeros, ten result bits msb first, two zeros
// - 8-bit: four zeros, eight result bits msb first, four zeros
// - select low starts a conversion and frames the transfer
// - after conversion the track-and-hold returns to tracking
// - result code is straight unsigned binary
`timescale 1ns/10ps
`default_nettype none
module asr_readout #(
	parameter int unsigned P_RES = asr_pkg::RES_12
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [asr_pkg::CODE_W-1:0] i_analog_input,
	input wire logic i_analog_valid,
	output logic o_analog_ready,
	output logic o_tracking,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	output logic o_serial_result_out,
	output logic o_serial_result_oe
);
	// ---------------- core domain: input buffer and track-and-hold
	logic [asr_pkg::CODE_W-1:0] buf_data;
	logic buf_valid, buf_pop;
	asr_pkg::asr_th_e st_r, st_nxt;
	logic [asr_pkg::CODE_W-1:0] track_r, track_nxt, held_r, held_nxt;
	logic cs_m_r, cs_s_r, dn_m_r, dn_s_r, dn_d_r;
	logic cs_low, done_evt;
	logic done_tgl_r, done_tgl_nxt;

	asr_buf2 #(
		.W(asr_pkg::CODE_W),
		.DEPTH(asr_pkg::BUF_DEPTH)
	) u_buf (
		.i_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_data(i_analog_input),
		.i_valid(i_analog_valid),
		.o_ready(o_analog_ready),
		.o_data(buf_data),
		.o_valid(buf_valid),
		.i_ready(buf_pop)
	);

	assign cs_low = ~cs_s_r;
	assign done_evt = dn_s_r ^ dn_d_r;
	// the sample only moves while tracking; holding stalls the buffer
	assign buf_pop = buf_valid & (st_r != asr_pkg::ST_HOLD);

	always_comb begin
		st_nxt = st_r;
		track_nxt = track_r;
		held_nxt = held_r;
		if (buf_pop) begin
			track_nxt = buf_data;
		end
		case (st_r)
			asr_pkg::ST_TRACK: begin
				if (cs_low) begin
					st_nxt = asr_pkg::ST_HOLD;
					held_nxt = track_r;
				end
			end
			asr_pkg::ST_HOLD: begin
				if (done_evt) begin
					st_nxt = asr_pkg::ST_DONE;
				end else if (!cs_low) begin
					st_nxt = asr_pkg::ST_TRACK;
				end
			end
			asr_pkg::ST_DONE: begin
				if (!cs_low) begin
					st_nxt = asr_pkg::ST_TRACK;
				end
			end
			default: st_nxt = asr_pkg::ST_TRACK;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= asr_pkg::ST_TRACK;
			track_r <= asr_pkg::CODE_ZERO;
			held_r <= asr_pkg::CODE_ZERO;
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			dn_m_r <= 1'b0;
			dn_s_r <= 1'b0;
			dn_d_r <= 1'b0;
			o_tracking <= 1'b1;
		end else begin
			st_r <= st_nxt;
			track_r <= track_nxt;
			held_r <= held_nxt;
			cs_m_r <= i_cs_n;
			cs_s_r <= cs_m_r;
			dn_m_r <= done_tgl_r;
			dn_s_r <= dn_m_r;
			dn_d_r <= dn_s_r;
			o_tracking <= (st_nxt != asr_pkg::ST_HOLD);
		end
	end

	// ---------------- link domain: conversion steps and shift-out
	// held_r is quasi-static: written before the first result bit is
	// needed and kept until the conversion's end has crossed back
	logic link_rst_n;
	logic [asr_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [asr_pkg::CODE_W-1:0] acc_r, acc_nxt, test;
	asr_pkg::asr_pin_s pin_r, pin_nxt;
	logic decide, in_data;

	// select high holds the link logic idle and releases the pin
	assign link_rst_n = i_rst_n & ~i_cs_n;
	assign o_serial_result_out = pin_r.data;
	assign o_serial_result_oe = pin_r.oe;

	always_comb begin
		cnt_nxt = cnt_r;
		acc_nxt = acc_r;
		pin_nxt = pin_r;
		done_tgl_nxt = done_tgl_r;
		in_data = (cnt_r >= asr_pkg::CNT_LEAD) &&
			(cnt_r < asr_pkg::CNT_LEAD + asr_pkg::CNT_W'(P_RES));
		test = acc_r | asr_pkg::trial_mask(cnt_r, P_RES);
		decide = (held_r >= test);
		if (cnt_r < asr_pkg::CNT_END) begin
			cnt_nxt = cnt_r + 1'b1;
			pin_nxt.oe = 1'b1;
			pin_nxt.data = in_data & decide;
			if (in_data && decide) begin
				acc_nxt = test;
			end
			if (cnt_r == asr_pkg::CNT_LEAD + asr_pkg::CNT_W'(P_RES - 1)) begin
				done_tgl_nxt = ~done_tgl_r;
			end
		end else begin
			pin_nxt.oe = 1'b0;
			pin_nxt.data = 1'b0;
		end
	end

	always_ff @(negedge i_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt_r <= '0;
			acc_r <= asr_pkg::CODE_ZERO;
			pin_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			acc_r <= acc_nxt;
			pin_r <= pin_nxt;
		end
	end

	// the event toggle must survive select going high
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_tgl_r <= 1'b0;
		end else begin
			done_tgl_r <= done_tgl_nxt;
		end
	end
endmodule // asr_readout
`default_nettype wire

// >>> tb/asr_readout_assertions.sv
// port checks for the serial result readout
`timescale 1ns/10ps
`default_nettype none
module asr_readout_assertions #(
	parameter int unsigned P_RES = asr_pkg::RES_12
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic o_analog_ready,
	input wire logic o_tracking,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic o_serial_result_out,
	input wire logic o_serial_result_oe
);
	logic [4:0] cnt_r;
	// rising serial edges seen in this frame
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n)
			cnt_r <= 5'h00;
		else if (cnt_r != 5'h1f)
			cnt_r <= cnt_r + 5'h01;
	end
	first_edge_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
		cnt_r == 5'h00 |-> !o_serial_result_oe) else $error("pin driven before first edge");
	frame_oe_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
		cnt_r < 5'h10 |-> o_serial_result_oe) else $error("pin not driven in frame");
	lead_zero_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
		cnt_r < 5'h04 |-> !o_serial_result_out) else $error("lead bit not zero");
	tail_zero_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
		cnt_r >= 4 + P_RES && cnt_r < 16 |-> !o_serial_result_out) else $error("tail not zero");
	release_end_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
		cnt_r == 5'h10 |-> !o_serial_result_oe) else $error("pin kept after frame");
	hold_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(i_cs_n) |-> ##[1:4] !o_tracking) else $error("no hold after select");
	track_back_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(i_cs_n) |-> ##[0:4] o_tracking) else $error("no return to tracking");
	buf_drain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_tracking && !o_analog_ready |-> ##[1:3] o_analog_ready) else $error("no drain");
endmodule // asr_readout_assertions
bind asr_readout asr_readout_assertions #(.P_RES(P_RES)) u_chk(.i_core_clk, .i_rst_n,
	.o_analog_ready, .o_tracking, .i_sclk, .i_cs_n, .o_serial_result_out, .o_serial_result_oe);
`default_nettype wire

// >>> tb/asr_host_model.sv
// host serial master: select, serial clock, bit capture
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
	input wire logic i_oe,
	input wire logic i_dat,
	output logic o_sclk,
	output logic o_cs_n
);
	logic pin = 1'b0;
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
	end
	// n falling edges, bits taken on rising edges
	task automatic frame(input int n, output logic [15:0] w);
		w = 16'h0000;
		#7 o_cs_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++) begin
			o_sclk = 1'b0;
			#24;
			pin = i_oe ? i_dat : ~pin; // released pin shows no stale level
			if (i < 16)
				w = {w[14:0], pin};
			o_sclk = 1'b1;
			#24;
		end
		o_cs_n = 1'b1;
		#100;
	endtask
endmodule // asr_host_model
`default_nettype wire

// >>> tb/asr_readout_bench.sv
// testbench for the serial result readout
`timescale 1ns/10ps
`default_nettype none
module asr_readout_bench;
	localparam int unsigned RES = asr_pkg::RES_10;
	logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0;
	logic [asr_pkg::CODE_W-1:0] din = 12'h000;
	wire logic rdy, trk, sclk, cs_n, dout, oe;
	logic [15:0] w;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	asr_readout #(.P_RES(RES)) i_dut(.i_core_clk(clk), .i_rst_n(rst_n), .i_analog_input(din),
		.i_analog_valid(vld), .o_analog_ready(rdy), .o_tracking(trk), .i_sclk(sclk),
		.i_cs_n(cs_n), .o_serial_result_out(dout), .o_serial_result_oe(oe));
	asr_host_model i_host(.i_oe(oe), .i_dat(dout), .o_sclk(sclk), .o_cs_n(cs_n));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic push(input logic [11:0] d);
		@(negedge clk);
		vld = 1'b1;
		din = d;
		while (rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
		vld = 1'b0;
	endtask
	task automatic t_codes;
		logic [11:0] c [4] = '{12'h000, 12'h3ff, 12'h2a5, 12'h001};
		foreach (c[i]) begin
			push(c[i]);
			repeat (3) @(negedge clk);
			i_host.frame(17, w);
			chk(w, 16'(c[i]) << (asr_pkg::CODE_W - RES));
			chk({15'h0000, oe}, 16'h0000);
		end
		$display("codes test done");
	endtask
	task automatic t_hold;
		fork
			i_host.frame(17, w);
			begin
				wait (trk === 1'b0);
				push(12'h155);
				push(12'h0aa);
				@(negedge clk);
				chk({15'h0000, rdy}, 16'h0000);
			end
		join
		chk(w, 16'h0004);
		i_host.frame(17, w);
		chk(w, 16'h02a8);
		$display("hold test done");
	endtask
	task automatic t_abort;
		push(12'h3ff);
		repeat (3) @(negedge clk);
		i_host.frame(6, w);
		chk(w, 16'h0003);
		chk({14'h0000, oe, trk}, 16'h0001);
		i_host.frame(17, w);
		chk(w, 16'h0ffc);
		$display("abort test done");
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_codes;
		t_hold;
		t_abort;
		tally_and_finish;
	end
endmodule // asr_readout_bench
`default_nettype wire
